//--- sim/gpdl_pins.sv
`timescale 1ns/1ps
module gpdl_pins (
  // Outside world
  input wire [15:0] ext_level,
  output wire [15:0] pin_input_level
);
  // Pins driven hard, no float modelled
  assign pin_input_level = ext_level;
endmodule

//--- sim/gpdl_port_bench.sv
`timescale 1ns/1ps
module gpdl_port_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [15:0] ext = 16'h5a3c;
  wire [31:0] prdata, cfg, cfg_hi;
  wire [15:0] pin, pout;
  wire pready, pslverr, key;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #20 pclk = ~pclk;
  gpdl_pins gpdl_pins_inst (.ext_level(ext), .pin_input_level(pin));
  gpdl_port gpdl_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_input_level(pin), .pin_output_level(pout),
    .pin_config_lo(cfg), .pin_config_hi(cfg_hi), .freeze_key(key));
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Let the access edge land before looking
    @(negedge pclk);
  endtask
  task automatic t_status;
    xfer(0, 8'h0c, 0);
    chk(rd, 32'h0000_a000);
    chk(cfg, 32'h4444_4444);
    chk(cfg_hi, 32'h8884_4444);
    xfer(1, 8'h08, 32'h0000_ffff);
    xfer(0, 8'h08, 0);
    chk(rd, 32'h0000_5a3c);
    @(posedge pclk);
    ext <= 16'hc3a5;
    repeat (3) @(posedge pclk);
    xfer(0, 8'h08, 0);
    chk(rd, 32'h0000_c3a5);
    xfer(0, 8'h20, 0);
    chk(er, 1);
  endtask
  task automatic t_outputs;
    xfer(1, 8'h0c, 32'h0000_1234);
    chk(pout, 16'h1234);
    xfer(1, 8'h10, 32'h0003_0101);
    chk(pout, 16'h1335);
    xfer(1, 8'h14, 32'h0000_0300);
    chk(pout, 16'h1035);
  endtask
  task automatic t_freeze;
    xfer(1, 8'h00, 32'h1111_2222);
    chk(cfg, 32'h1111_2222);
    xfer(1, 8'h18, 32'h0001_0001);
    xfer(1, 8'h18, 32'h0001_0001);
    xfer(0, 8'h08, 0);
    xfer(0, 8'h18, 0);
    chk(key, 0);
    xfer(1, 8'h18, 32'h0001_0001);
    xfer(1, 8'h18, 32'h0001_0001);
    xfer(0, 8'h18, 0);
    chk(rd, 32'h0000_0001);
    xfer(0, 8'h18, 0);
    chk(rd, 32'h0001_0001);
    xfer(1, 8'h00, 0);
    chk(cfg, 32'h0000_0002);
    xfer(1, 8'h04, 32'h0000_0000);
    chk(cfg_hi, 32'h0000_0000);
    xfer(1, 8'h18, 0);
    xfer(0, 8'h18, 0);
    chk(rd, 32'h0001_0001);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_status;
    t_outputs;
    t_freeze;
    stop_test;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test;
    end
  end
endmodule

//--- sim/gpdl_port_checker.sv
`timescale 1ns/1ps
module gpdl_port_checker (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire [15:0] pin_input_level,
  input wire [15:0] pin_output_level,
  input wire [31:0] pin_config_lo,
  input wire [31:0] pin_config_hi,
  input wire freeze_key
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire [15:0] lo = pwdata[15:0];
  wire [15:0] hi = pwdata[31:16];
  wire [15:0] po = pin_output_level;
  sequence wr_key;
    wr && paddr == 8'h18 && pwdata[16];
  endsequence
  sequence rd_key;
    rd && paddr == 8'h18;
  endsequence
  chk_out_write: assert property (wr && paddr == 8'h0c |=> po == $past(lo))
    else $error("output write lost");
  chk_set_clear: assert property (wr && paddr == 8'h10 |=>
    po == (($past(po) & ~$past(hi)) | $past(lo))) else $error("set/clear wrong");
  chk_clear_only: assert property (wr && paddr == 8'h14 |=>
    po == ($past(po) & ~$past(lo))) else $error("clear wrong");
  chk_key_sticky: assert property (freeze_key |=> freeze_key)
    else $error("key dropped");
  chk_key_cause: assert property ($rose(freeze_key) |-> $past(rd) && $past(paddr) == 8'h18)
    else $error("key rose without read");
  chk_key_seq: assert property (wr_key ##3 wr_key ##3 rd_key |=> freeze_key)
    else $error("key not armed");
  chk_input_status: assert property ($stable(pin_input_level)[*4] ##0 (rd &&
    paddr == 8'h08) |-> prdata == {16'h0000, pin_input_level}) else $error("status wrong");
  chk_cfg_open: assert property (!freeze_key && wr && paddr == 8'h00 |=>
    pin_config_lo == $past(pwdata)) else $error("config write lost");
endmodule
bind gpdl_port gpdl_port_checker gpdl_port_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_input_level(pin_input_level),
  .pin_output_level(pin_output_level), .pin_config_lo(pin_config_lo),
  .pin_config_hi(pin_config_hi), .freeze_key(freeze_key));

//--- verilog/gpdl_map.vh
`ifndef GPDL_MAP_VH
`define GPDL_MAP_VH

// Register byte offsets
`define GPDL_OFF_CFG_LO 8'h00
`define GPDL_OFF_CFG_HI 8'h04
`define GPDL_OFF_IN 8'h08
`define GPDL_OFF_OUT 8'h0c
`define GPDL_OFF_SETCLR 8'h10
`define GPDL_OFF_CLR 8'h14
`define GPDL_OFF_FREEZE 8'h18

// Field positions
`define GPDL_KEY_BIT 16
`define GPDL_CLR_HI 31
`define GPDL_CLR_LO 16

// Reset values
`define GPDL_OUT_RST_P0 16'ha000
`define GPDL_OUT_RST_P1 16'h0010
`define GPDL_OUT_RST_PN 16'h0000
`define GPDL_CFG_RST 32'h4444_4444
`define GPDL_CFG_HI_RST_P0 32'h8884_4444
`define GPDL_FREEZE_RST 16'h0000

`endif

//--- verilog/gpdl_port.v
// Function
// - Each of 16 pin levels is captured into the read-only input status bits.
// - Input status at 0x08, upper half reads zero, lower half follows pins.
// - 16-bit read/write output value drives each pin level directly.
// - Output reset a000 on port 0, 0010 on port 1, zero elsewhere.
// - Set/clear lower half ones set matching output bits; zeros do nothing.
// - Set/clear upper half ones clear output bit sixteen lower.
// - Clear register lower half ones clear output bits; rest ignored.
// - With key set, pins whose freeze bit is one refuse configuration writes.
// - Key bit 16 is set only by the key sequence, always readable.
// - Key sequence is write 1, write 1, read 0, read 1.
// - Once key is set, freeze register and locked fields hold until reset.
// - Freezing covers the mode and config nibbles at offsets 0x00 and 0x04.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "gpdl_map.vh"

module gpdl_port #(
  parameter PORT_INDEX = 0
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Pins
  input wire [15:0] pin_input_level,
  output wire [15:0] pin_output_level,
  // Per-pin mode and config fields, pins 0..7 and 8..15
  output wire [31:0] pin_config_lo,
  output wire [31:0] pin_config_hi,
  // Freeze status
  output wire freeze_key
);

  localparam [15:0] OUT_RST = (PORT_INDEX == 0) ? `GPDL_OUT_RST_P0 :
                              (PORT_INDEX == 1) ? `GPDL_OUT_RST_P1 : `GPDL_OUT_RST_PN;
  localparam [31:0] CFG_HI_RST = (PORT_INDEX == 0) ? `GPDL_CFG_HI_RST_P0 : `GPDL_CFG_RST;

  localparam [1:0] SEQ_IDLE = 2'b00;
  localparam [1:0] SEQ_W1 = 2'b01;
  localparam [1:0] SEQ_W2 = 2'b10;

  // Pin synchroniser
  reg [15:0] pin_meta_q;
  reg [15:0] pin_sync_q;

  // Output level register
  reg [15:0] out_q;
  reg [15:0] out_d;

  // Mode and config fields
  reg [31:0] cfg_lo_q;
  reg [31:0] cfg_lo_d;
  reg [31:0] cfg_hi_q;
  reg [31:0] cfg_hi_d;

  // Freeze pattern, key and sequence
  reg [15:0] freeze_q;
  reg [15:0] freeze_d;
  reg key_q;
  reg key_d;
  reg [1:0] seq_q;
  reg [1:0] seq_d;
  reg key_set;

  // Read path
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg [31:0] rdata;

  // Address decode
  reg hit_cfg_lo;
  reg hit_cfg_hi;
  reg hit_in;
  reg hit_out;
  reg hit_setclr;
  reg hit_clr;
  reg hit_freeze;
  reg hit_none;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire wr_lock = wr_en & hit_freeze & pwdata[`GPDL_KEY_BIT];
  wire rd_freeze = access & ~pwrite & hit_freeze;
  wire [15:0] pin_frozen = key_q ? freeze_q : 16'h0000;
  wire [31:0] cfg_lo_wmask;
  wire [31:0] cfg_hi_wmask;

  // Zero wait states keeps the bus simple; read data is staged in setup
  assign pready = 1'b1;
  assign pslverr = access & hit_none;
  assign prdata = prdata_q;
  assign pin_output_level = out_q;
  assign pin_config_lo = cfg_lo_q;
  assign pin_config_hi = cfg_hi_q;
  assign freeze_key = key_q;

  always @* begin
    hit_cfg_lo = 1'b0;
    hit_cfg_hi = 1'b0;
    hit_in = 1'b0;
    hit_out = 1'b0;
    hit_setclr = 1'b0;
    hit_clr = 1'b0;
    hit_freeze = 1'b0;
    hit_none = 1'b0;
    if (paddr == `GPDL_OFF_CFG_LO) begin
      hit_cfg_lo = 1'b1;
    end else if (paddr == `GPDL_OFF_CFG_HI) begin
      hit_cfg_hi = 1'b1;
    end else if (paddr == `GPDL_OFF_IN) begin
      hit_in = 1'b1;
    end else if (paddr == `GPDL_OFF_OUT) begin
      hit_out = 1'b1;
    end else if (paddr == `GPDL_OFF_SETCLR) begin
      hit_setclr = 1'b1;
    end else if (paddr == `GPDL_OFF_CLR) begin
      hit_clr = 1'b1;
    end else if (paddr == `GPDL_OFF_FREEZE) begin
      hit_freeze = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  // Each pin owns one 4-bit mode/config nibble
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_mask
      assign cfg_lo_wmask[4*g+3:4*g] = {4{~pin_frozen[g]}};
      assign cfg_hi_wmask[4*g+3:4*g] = {4{~pin_frozen[g+8]}};
    end
  endgenerate

  always @* begin
    rdata = 32'h0000_0000;
    if (hit_cfg_lo) begin
      rdata = cfg_lo_q;
    end else if (hit_cfg_hi) begin
      rdata = cfg_hi_q;
    end else if (hit_in) begin
      rdata = {16'h0000, pin_sync_q};
    end else if (hit_out) begin
      rdata = {16'h0000, out_q};
    end else if (hit_freeze) begin
      rdata = {15'h0000, key_q, freeze_q};
    end
  end

  // Staged at setup so the access phase never waits
  always @* begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = rdata;
    end
  end

  always @* begin
    out_d = out_q;
    if (wr_en && hit_out) begin
      out_d = pwdata[15:0];
    end else if (wr_en && hit_setclr) begin
      // Clear first, then set, so a set on the same pin wins
      out_d = (out_q & ~pwdata[`GPDL_CLR_HI:`GPDL_CLR_LO]) | pwdata[15:0];
    end else if (wr_en && hit_clr) begin
      out_d = out_q & ~pwdata[15:0];
    end
  end

  // Frozen nibbles keep their value, open ones take the write
  always @* begin
    cfg_lo_d = cfg_lo_q;
    if (wr_en && hit_cfg_lo) begin
      cfg_lo_d = (cfg_lo_q & ~cfg_lo_wmask) | (pwdata & cfg_lo_wmask);
    end
  end

  always @* begin
    cfg_hi_d = cfg_hi_q;
    if (wr_en && hit_cfg_hi) begin
      cfg_hi_d = (cfg_hi_q & ~cfg_hi_wmask) | (pwdata & cfg_hi_wmask);
    end
  end

  // Pattern is read-only once the key is set
  always @* begin
    freeze_d = freeze_q;
    if (wr_en && hit_freeze && !key_q) begin
      freeze_d = pwdata[15:0];
    end
  end

  // No path clears the key short of reset
  always @* begin
    key_d = key_q;
    if (key_set) begin
      key_d = 1'b1;
    end
  end

  // Key sequence recogniser; idle for good once the key is set
  always @* begin
    seq_d = seq_q;
    key_set = 1'b0;
    if (access && !key_q) begin
      case (seq_q)
        SEQ_IDLE: begin
          if (wr_lock) begin
            seq_d = SEQ_W1;
          end
        end
        SEQ_W1: begin
          if (wr_lock && pwdata[15:0] == freeze_q) begin
            seq_d = SEQ_W2;
          end else if (wr_lock) begin
            seq_d = SEQ_W1;
          end else begin
            seq_d = SEQ_IDLE;
          end
        end
        SEQ_W2: begin
          if (rd_freeze) begin
            // This read still returns key 0; the next one sees 1
            seq_d = SEQ_IDLE;
            key_set = 1'b1;
          end else if (wr_lock) begin
            seq_d = SEQ_W1;
          end else begin
            seq_d = SEQ_IDLE;
          end
        end
        default: begin
          seq_d = SEQ_IDLE;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 16'h0000;
      pin_sync_q <= 16'h0000;
    end else begin
      // Pins are asynchronous to pclk
      pin_meta_q <= pin_input_level;
      pin_sync_q <= pin_meta_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= OUT_RST;
    end else begin
      out_q <= out_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_lo_q <= `GPDL_CFG_RST;
      cfg_hi_q <= CFG_HI_RST;
    end else begin
      cfg_lo_q <= cfg_lo_d;
      cfg_hi_q <= cfg_hi_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_q <= `GPDL_FREEZE_RST;
      key_q <= 1'b0;
      seq_q <= SEQ_IDLE;
    end else begin
      freeze_q <= freeze_d;
      key_q <= key_d;
      seq_q <= seq_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

endmodule
